// ==== design/bdm_pkg.sv ====
// Constants shared by the bridge driver serial control and fault monitor.
// Assumes a 50 MHz core clock; all times are converted to core cycles here.
package bdm_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CORE_CLK_MHZ     = 50;
    // Least time from enable rising to the first accepted frame
    localparam int ENABLE_SETUP_NS  = 10000;
    localparam int ENABLE_SETUP_CYC = (ENABLE_SETUP_NS * CORE_CLK_MHZ + 999) / 1000;
    // Least time of low load current before an open load is latched
    localparam int OL_FILTER_NS     = 100000;
    localparam int OL_FILTER_CYC    = (OL_FILTER_NS * CORE_CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------------
    // Structure
    // ------------------------------------------------------------------
    localparam int NSW = 8;                 // Four half bridges, low and high switch each
    localparam logic [7:0] FRAME_BITS = 8'h10;

    // Positions in the input synchroniser vector
    localparam int SY_CS  = 0;
    localparam int SY_EN  = 1;
    localparam int SY_TW  = 2;
    localparam int SY_TS  = 3;
    localparam int SY_UV  = 4;
    localparam int SY_OV  = 5;
    localparam int SY_OC  = 6;
    localparam int SY_OL  = SY_OC + NSW;
    localparam int SYNC_W = SY_OL + NSW;

    // ------------------------------------------------------------------
    // Address byte layout and register addresses
    // ------------------------------------------------------------------
    localparam int ADR_LSB_POS  = 0;
    localparam int ADR_LAST_POS = 1;
    localparam int ADR_LO       = 2;
    localparam int ADR_HI       = 6;
    localparam int ADR_OP_POS   = 7;
    localparam logic [4:0] ADDR_SWITCH_CTRL = 5'h00;
    localparam logic [4:0] ADDR_MASK_CTRL   = 5'h1a;
    localparam logic [4:0] ADDR_ID          = 5'h19;
    localparam logic [4:0] ADDR_GLOBAL      = 5'h06;
    localparam logic [4:0] ADDR_OC          = 5'h16;
    localparam logic [4:0] ADDR_OL          = 5'h01;
    localparam int MASK_OL_POS = 0;

    // ------------------------------------------------------------------
    // Global status byte fields and status register groups
    // ------------------------------------------------------------------
    localparam int GS_TPW   = 1;
    localparam int GS_TSD   = 2;
    localparam int GS_POWER_UP_CLEAR_FLAG  = 3;
    localparam int GS_OV    = 4;
    localparam int GS_UV    = 5;
    localparam int GS_LE    = 6;
    localparam int GS_FRAME = 7;
    localparam int TCH_GLOBAL = 0;
    localparam int TCH_OC     = 1;
    localparam int TCH_OL     = 2;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [NSW-1:0] RST_CTRL = 8'h00;
    localparam logic           RST_POWER_UP_CLEAR_FLAG = 1'b0;

endpackage

// ==== design/bdm_spi_fault_monitor.sv ====
// Serial control port and fault supervision of a quad half-bridge driver.
// Assumes: SCLK, CS and SDI come from an external master and are asynchronous to
// core_clk_i; analog comparator levels are asynchronous too; rst_b_i is the
// logic-supply power-on reset.

// Summary of operation
// - Warning temperature latches the warning flag; outputs stay on.
// - Shutdown temperature latches flag and blocks all outputs; control bits are kept.
// - Clearing the warning flag only works once temperature is below warning.
// - Supply low blocks outputs, latches its flag, outputs resume on recovery.
// - Supply high blocks outputs, latches its flag, outputs resume on recovery.
// - Logic-supply reset holds everything in reset, SDO floats, link ignored.
// - After any reset the power-up flag reads 0 until software clears it.
// - Low current for the filter time on an active switch latches open load.
// - Sixteen-bit frames, sample on SCLK fall, shift on rise, in-frame response.
// - CS rising decodes the word and releases SDO.
// - Flags clear and settings change only by host commands or reset, never by themselves.
// - Frames starting before the enable setup delay are ignored.
// - Before the first SCLK rise SDO shows fault bit OR SDI.
// - Power-up flag resets to 0, so the fault bit reads 1 until set.
// - The first eight SCLK cycles carry the global status byte.
// - Fault bit is the OR of all global faults and inverted power-up flag.
// - Open loads feed the fault bit only while the mask is 0.
// - A protocol error shows in status bit 7 from the following frame.
// - Clock counts other than 0 or multiples of 8 from 16 to 248 are errors.
// - Unused address, address LSB 0 or last-header marker 0 are errors.
// - SCLK high at either CS edge is an error.
// - Bit 1 of the address byte is the last-header marker.
// - Address bit 7 selects write or read-and-clear versus read.
// - Enable low resets all settings and flags and switches every output off.
// - A clear is dropped if its register gained a new fault in that frame.
module bdm_spi_fault_monitor
    import bdm_pkg::*;
#(
    parameter int         OL_FILTER_COUNT = OL_FILTER_CYC,
    parameter logic [7:0] DEVICE_ID       = 8'h5a  // Arbitrary identification value
) (
    // Core clock and logic-supply reset
    input  wire logic           core_clk_i,
    input  wire logic           rst_b_i,
    // Mode pin and comparator levels
    input  wire logic           enable_i,
    input  wire logic           temp_warn_i,
    input  wire logic           temp_shutdown_i,
    input  wire logic           supply_low_i,
    input  wire logic           supply_high_i,
    input  wire logic [NSW-1:0] overcurrent_i,
    input  wire logic [NSW-1:0] undercurrent_i,
    // Serial link
    input  wire logic           sclk_i,
    input  wire logic           cs_b_i,
    input  wire logic           sdi_i,
    output logic                sdo_o,
    output logic                sdo_oe_o,
    // Power stage gate enables
    output logic [NSW-1:0]      switch_drive_o
);

    localparam int SUW = $clog2(ENABLE_SETUP_CYC + 1);
    localparam int OLW = $clog2(OL_FILTER_COUNT + 1);

    typedef struct packed {
        logic [SYNC_W-1:0]          sy1;
        logic [SYNC_W-1:0]          sy2;
        logic                       cs_d;
        logic                       frame_ok;
        logic [SUW-1:0]             su_cnt;
        logic                       ready;
        logic [NSW-1:0]             ctrl;
        logic                       mask;
        logic                       thermal_warning_flag;
        logic                       thermal_shutdown_flag;
        logic                       uv;
        logic                       ov;
        logic                       power_up_clear_flag;
        logic                       ffault;
        logic [NSW-1:0]             oc;
        logic [NSW-1:0]             ol;
        logic [NSW-1:0][OLW-1:0]    olcnt;
        logic [2:0]                 touch;
        logic [7:0]                 img_gs;
        logic                       img_gef;
        logic [NSW-1:0]             img_ctrl;
        logic                       img_mask;
        logic [NSW-1:0]             img_oc;
        logic [NSW-1:0]             img_ol;
        logic [NSW-1:0]             drive;
    } bdm_core_t;

    typedef struct packed {
        logic        tog;
        logic [7:0]  cnt;
        logic [15:0] word;
    } bdm_rx_t;

    typedef struct packed {
        logic        tog;
        logic [4:0]  ptr;
        logic        sdo;
    } bdm_tx_t;

    typedef struct packed {
        logic        tog;
        logic [7:0]  cnt;
        logic [15:0] word;
        logic        pol;
    } bdm_hold_t;

    bdm_core_t      s, n;
    bdm_rx_t        rx, rxn;
    bdm_tx_t        tx, txn;
    bdm_hold_t      hd, hdn;
    logic           cf_pol;
    logic           cs_s, en_s, tw_s, ts_s, uv_s, ov_s;
    logic [NSW-1:0] oc_s, ol_s, oc_set, ol_set;
    logic           cs_fall, dec, err, cnt_err, hdr_err, act;
    logic           ev_g, ev_oc, ev_ol, le, le_gef;
    logic [7:0]     adr, dat;
    logic [4:0]     reg_a;
    logic           rx_new, tx_new;
    logic [4:0]     idx;
    logic [15:0]    tx_word;

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic addr_known(input logic [4:0] a);
        addr_known = (a == ADDR_SWITCH_CTRL) || (a == ADDR_MASK_CTRL) || (a == ADDR_ID) ||
                     (a == ADDR_GLOBAL) || (a == ADDR_OC) || (a == ADDR_OL);
    endfunction

    // Response byte for an address; frozen images keep it steady during a frame
    function automatic logic [7:0] resp_byte(input logic [4:0] a, input bdm_core_t c);
        resp_byte = 8'h00;
        if (addr_known(a)) begin
            unique case (a)
                ADDR_SWITCH_CTRL: resp_byte = c.img_ctrl;
                ADDR_MASK_CTRL:   resp_byte = {7'h00, c.img_mask};
                ADDR_ID:          resp_byte = DEVICE_ID;
                ADDR_GLOBAL:      resp_byte = c.img_gs;
                ADDR_OC:          resp_byte = c.img_oc;
                ADDR_OL:          resp_byte = c.img_ol;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Core domain: synchronised levels
    // ------------------------------------------------------------------
    assign cs_s = s.sy2[SY_CS];
    assign en_s = s.sy2[SY_EN];
    assign tw_s = s.sy2[SY_TW];
    assign ts_s = s.sy2[SY_TS];
    assign uv_s = s.sy2[SY_UV];
    assign ov_s = s.sy2[SY_OV];
    assign oc_s = s.sy2[SY_OC +: NSW];
    assign ol_s = s.sy2[SY_OL +: NSW];

    // Frame words are read from the hold stage only after CS high is synchronised
    assign adr   = hd.word[7:0];
    assign dat   = hd.word[15:8];
    assign reg_a = adr[ADR_HI:ADR_LO];

    // Next core state
    always_comb begin
        n = s;
        n.sy1 = {undercurrent_i, overcurrent_i, supply_high_i, supply_low_i,
                 temp_shutdown_i, temp_warn_i, enable_i, cs_b_i};
        n.sy2 = s.sy1;
        n.cs_d = cs_s;
        cs_fall = s.cs_d & ~cs_s;
        dec = ~s.cs_d & cs_s & s.frame_ok;
        if (cs_fall) begin
            n.frame_ok = s.ready;
        end
        if (s.su_cnt != SUW'(ENABLE_SETUP_CYC)) begin
            n.su_cnt = s.su_cnt + SUW'(1);
        end
        n.ready = (n.su_cnt == SUW'(ENABLE_SETUP_CYC));
        // Protocol checks on the word taken at CS rising
        cnt_err = (hd.cnt != 8'h00) &&
                  ((hd.cnt[2:0] != 3'h0) || (hd.cnt < FRAME_BITS));
        hdr_err = (hd.cnt != 8'h00) && (!adr[ADR_LSB_POS] ||
                  !adr[ADR_LAST_POS] || !addr_known(reg_a));
        err = dec & (cnt_err | hdr_err | hd.pol);
        act = dec & ~err & (hd.cnt == FRAME_BITS) & adr[ADR_OP_POS];
        // Open load filters: count consecutive cycles of low current
        ol_set = '0;
        for (int i = 0; i < NSW; i++) begin
            if (s.drive[i] && ol_s[i]) begin
                if (s.olcnt[i] != OLW'(OL_FILTER_COUNT)) begin
                    n.olcnt[i] = s.olcnt[i] + OLW'(1);
                end
                ol_set[i] = (s.olcnt[i] >= OLW'(OL_FILTER_COUNT - 1));
            end else begin
                n.olcnt[i] = '0;
            end
        end
        oc_set = s.drive & oc_s;
        ev_g  = (tw_s & ~s.thermal_warning_flag) | (ts_s & ~s.thermal_shutdown_flag) | (uv_s & ~s.uv) | (ov_s & ~s.ov);
        ev_oc = |(oc_set & ~s.oc);
        ev_ol = |(ol_set & ~s.ol);
        // Faults that arrive while a frame is open void a clear of their register
        if (cs_fall) begin
            n.touch = {ev_ol, ev_oc, ev_g};
        end else if (!cs_s) begin
            n.touch = s.touch | {ev_ol, ev_oc, ev_g};
        end
        // Host writes; only these, the clears below and sleep change settings or clear flags
        if (act && (reg_a == ADDR_SWITCH_CTRL)) begin
            n.ctrl = dat;
        end
        if (act && (reg_a == ADDR_MASK_CTRL)) begin
            n.mask = dat[MASK_OL_POS];
        end
        if (act && (reg_a == ADDR_GLOBAL) && !s.touch[TCH_GLOBAL] && !ev_g) begin
            if (!tw_s) begin
                n.thermal_warning_flag = 1'b0;
            end
            n.thermal_shutdown_flag    = 1'b0;
            n.uv     = 1'b0;
            n.ov     = 1'b0;
            n.ffault = 1'b0;
            n.power_up_clear_flag   = 1'b1;
        end
        if (act && (reg_a == ADDR_OC) && !s.touch[TCH_OC] && !ev_oc) begin
            n.oc = '0;
        end
        if (act && (reg_a == ADDR_OL) && !s.touch[TCH_OL] && !ev_ol) begin
            n.ol = '0;
        end
        // Sets come last so an event in the clearing cycle is kept
        n.thermal_warning_flag = n.thermal_warning_flag | tw_s;
        n.thermal_shutdown_flag = n.thermal_shutdown_flag | ts_s;
        n.uv  = n.uv | uv_s;
        n.ov  = n.ov | ov_s;
        n.oc  = n.oc | oc_set;
        n.ol  = n.ol | ol_set;
        if (err) begin
            n.ffault = 1'b1;
        end
        // Sleep: enable low wipes everything except the synchronisers and the CS edge register
        if (!en_s) begin
            n = '0;
            n.sy1  = {undercurrent_i, overcurrent_i, supply_high_i, supply_low_i,
                      temp_shutdown_i, temp_warn_i, enable_i, cs_b_i};
            n.sy2  = s.sy1;
            n.cs_d = cs_s;
            n.ctrl = RST_CTRL;
            n.power_up_clear_flag = RST_POWER_UP_CLEAR_FLAG;
        end
        le     = (|n.oc) | (|n.ol);
        le_gef = (|n.oc) | ((|n.ol) & ~n.mask);
        // Images only move between frames, so the link sees stable data
        if (cs_s) begin
            n.img_gs           = 8'h00;
            n.img_gs[GS_TPW]   = n.thermal_warning_flag;
            n.img_gs[GS_TSD]   = n.thermal_shutdown_flag;
            n.img_gs[GS_POWER_UP_CLEAR_FLAG]  = n.power_up_clear_flag;
            n.img_gs[GS_OV]    = n.ov;
            n.img_gs[GS_UV]    = n.uv;
            n.img_gs[GS_LE]    = le;
            n.img_gs[GS_FRAME] = n.ffault;
            n.img_gef  = n.ffault | le_gef | n.uv | n.ov | ~n.power_up_clear_flag |
                         n.thermal_shutdown_flag | n.thermal_warning_flag;
            n.img_ctrl = n.ctrl;
            n.img_mask = n.mask;
            n.img_oc   = n.oc;
            n.img_ol   = n.ol;
        end
        // Gate enables: control bit and no blocking condition
        n.drive = n.ctrl & ~n.oc &
                  {NSW{en_s & ~n.thermal_shutdown_flag & ~uv_s & ~ov_s}};
    end

    // Core state register; logic-supply reset clears everything
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign switch_drive_o = s.drive;

    // ------------------------------------------------------------------
    // Link domain: receive on falling SCLK
    // ------------------------------------------------------------------
    // A frame is new when the toggle matches the hold stage; avoids resetting on CS
    always_comb begin
        rxn = rx;
        rx_new = (rx.tog == hd.tog);
        if (rx_new) begin
            rxn.tog  = ~hd.tog;
            rxn.cnt  = 8'h01;
            rxn.word = {15'h0000, sdi_i};
        end else begin
            if (rx.cnt != 8'hff) begin
                rxn.cnt = rx.cnt + 8'h01;
            end
            if (rx.cnt < FRAME_BITS) begin
                rxn.word[rx.cnt[3:0]] = sdi_i;
            end
        end
    end

    always_ff @(negedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx <= '0;
        end else begin
            rx <= rxn;
        end
    end

    // ------------------------------------------------------------------
    // Link domain: transmit on rising SCLK
    // ------------------------------------------------------------------
    // Status byte first, then the addressed register, then zeros
    always_comb begin
        txn = tx;
        tx_new = (tx.tog == hd.tog);
        idx = tx_new ? 5'h00 : tx.ptr;
        tx_word = {resp_byte(rx.word[ADR_HI:ADR_LO], s), s.img_gs};
        txn.tog = ~hd.tog;
        txn.ptr = idx[4] ? idx : idx + 5'h01;
        txn.sdo = idx[4] ? 1'b0 : tx_word[idx[3:0]];
    end

    always_ff @(posedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx <= '0;
        end else begin
            tx <= txn;
        end
    end

    // ------------------------------------------------------------------
    // Link domain: CS edges
    // ------------------------------------------------------------------
    // SCLK level at the CS falling edge, for the polarity check
    always_ff @(negedge cs_b_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cf_pol <= 1'b0;
        end else begin
            cf_pol <= sclk_i;
        end
    end

    // Frame result frozen at CS rising; the core reads it after synchronising CS
    always_comb begin
        hdn = hd;
        // Only a clocked frame advances the toggle, so a zero-clock frame leaves both
        // shifters armed; a rise with no fall is a polarity error and costs one frame
        hdn.tog  = (rx.tog != hd.tog) ? ~hd.tog : hd.tog;
        hdn.cnt  = (rx.tog != hd.tog) ? rx.cnt : 8'h00;
        hdn.word = (rx.tog != hd.tog) ? rx.word : 16'h0000;
        hdn.pol  = cf_pol | sclk_i;
    end

    always_ff @(posedge cs_b_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hd <= '0;
        end else begin
            hd <= hdn;
        end
    end

    // SDO shows fault OR SDI until the first rise, then the shifter; floats when idle
    assign sdo_o    = (tx.tog != hd.tog) ? tx.sdo : (s.img_gef | sdi_i);
    assign sdo_oe_o = ~cs_b_i & s.ready;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_tpw_set;
        (en_s && tw_s) |=> s.thermal_warning_flag;
    endproperty
    a_tpw_set: assert property (p_tpw_set) else $error("warning flag not latched");

    property p_tsd_off;
        s.thermal_shutdown_flag |-> (switch_drive_o == '0);
    endproperty
    a_tsd_off: assert property (p_tsd_off) else $error("output on during shutdown");

    property p_tpw_keep;
        (act && (reg_a == ADDR_GLOBAL) && tw_s && en_s) |=> s.thermal_warning_flag;
    endproperty
    a_tpw_keep: assert property (p_tpw_keep) else $error("warning cleared while hot");

    property p_uv_off;
        uv_s |=> (switch_drive_o == '0) && (!$past(en_s) || s.uv);
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("supply low not handled");

    property p_ov_off;
        ov_s |=> (switch_drive_o == '0);
    endproperty
    a_ov_off: assert property (p_ov_off) else $error("output on in overvoltage");

    property p_power_up_clear_flag_gef;
        (!s.power_up_clear_flag && cs_s && !dec) |=> s.img_gef;
    endproperty
    a_power_up_clear_flag_gef: assert property (p_power_up_clear_flag_gef) else $error("fault bit low after reset");

    property p_cnt_err;
        (dec && en_s && (hd.cnt == 8'h0c)) |=> s.ffault ##1 s.img_gs[GS_FRAME];
    endproperty
    a_cnt_err: assert property (p_cnt_err) else $error("bad clock count not flagged");

    property p_hdr_err;
        (dec && en_s && (hd.cnt == FRAME_BITS) && !hd.word[ADR_LAST_POS]) |=> s.ffault;
    endproperty
    a_hdr_err: assert property (p_hdr_err) else $error("missing marker not flagged");

    property p_gate;
        (switch_drive_o & ~s.ctrl) == '0;
    endproperty
    a_gate: assert property (p_gate) else $error("switch on without control bit");

    property p_ol;
        (en_s && s.drive[0] && ol_s[0] && (s.olcnt[0] == OLW'(OL_FILTER_COUNT - 1)))
            |=> s.ol[0];
    endproperty
    a_ol: assert property (p_ol) else $error("open load not latched");

    property p_sleep;
        !en_s |=> (s.ctrl == '0) && !s.power_up_clear_flag && (switch_drive_o == '0);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep did not reset");

    c_write: cover property (act && (reg_a == ADDR_SWITCH_CTRL));
    c_zero:  cover property (dec && (hd.cnt == 8'h00));
    c_error: cover property (err);
    c_tsd:   cover property ($rose(s.thermal_shutdown_flag));

endmodule

// ==== verification/bdm_host_model.sv ====
// Host model: serial master that frames words to the fault monitor link.
// Assumes the bench calls xfer one frame at a time; link clock is 15 ns.
module bdm_host_model (
    // Link pins
    output logic      sclk_o,
    output logic      cs_b_o,
    output logic      sdi_o,
    input  wire logic sdo_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic lclk;
    // Free-running link clock; SCLK only pulses inside frames
    initial begin
        lclk = 1'b0;
        sclk_o = 1'b0;
        cs_b_o = 1'b1;
        sdi_o = 1'b0;
    end
    always #7.5 lclk = ~lclk;
    // One frame of n clocks, LSB first; g is SDO before the first rise
    task automatic xfer(input int n, input logic [15:0] w, output logic [15:0] r,
                        output logic g);
        r = 16'h0000;
        @(negedge lclk) cs_b_o = 1'b0;
        @(negedge lclk) g = sdo_i;
        for (int k = 0; k < n; k++) begin
            @(posedge lclk) sclk_o = 1'b1;
            sdi_o = w[k];
            @(negedge lclk) r[k] = sdo_i;
            sclk_o = 1'b0;
        end
        @(negedge lclk) cs_b_o = 1'b1;
        sdi_o = 1'b0;  // Pull-down level once released
        #200;  // Gap long enough for the core to decode
    endtask
endmodule

// ==== verification/tb_top.sv ====
// Testbench of the fault monitor: frame table first, then fault and enable cases.
// Assumes the host model as link partner and a 50 MHz core clock.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {int n; logic [15:0] w, m, e; logic g;} bdm_row_t;
    logic clk = 1'b0, rst_b = 1'b0, en = 1'b1, ts = 1'b0, ul = 1'b0;
    logic sclk, cs_b, sdi, sdo, sdo_oe, g;
    logic tw = 1'b0, ov = 1'b0;
    logic [7:0] oc = 8'h00, uc = 8'h00;
    // Released SDO has no pull, so the host sees the inverse while it floats
    wire sdo_bus = sdo_oe ? sdo : ~sdo;
    logic [7:0] drv;
    logic [15:0] r;
    int miscompares = 0, num_checks = 0;
    // Frame, checked response bits, expected response, expected fault bit
    bdm_row_t rows [0:12] = '{
        '{16, 16'h001b, 16'hffff, 16'h0000, 1'b1}, '{16, 16'h009b, 16'hffff, 16'h0000, 1'b1},
        '{16, 16'h001b, 16'hffff, 16'h0808, 1'b0}, '{16, 16'h0f83, 16'hffff, 16'h0008, 1'b0},
        '{16, 16'h0f03, 16'hffff, 16'h0f08, 1'b0}, '{16, 16'h0067, 16'hffff, 16'h5a08, 1'b0},
        '{16, 16'h001a, 16'h00ff, 16'h0008, 1'b0}, '{12, 16'h001b, 16'h0000, 16'h0000, 1'b1},
        '{16, 16'h009b, 16'hffff, 16'h8888, 1'b1}, '{0, 16'h0000, 16'h0000, 16'h0000, 1'b0},
        '{16, 16'h0019, 16'h00ff, 16'h0008, 1'b0}, '{16, 16'h009b, 16'hffff, 16'h8888, 1'b1},
        '{16, 16'h001b, 16'hffff, 16'h0808, 1'b0}};
    always #10 clk = ~clk;
    bdm_spi_fault_monitor #(.OL_FILTER_COUNT(20)) bdm_spi_fault_monitor_inst (
        .core_clk_i(clk), .rst_b_i(rst_b), .enable_i(en), .temp_warn_i(tw),
        .temp_shutdown_i(ts), .supply_low_i(ul), .supply_high_i(ov),
        .overcurrent_i(oc), .undercurrent_i(uc), .sclk_i(sclk), .cs_b_i(cs_b),
        .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .switch_drive_o(drv));
    bdm_host_model bdm_host_model_inst (.sclk_o(sclk), .cs_b_o(cs_b), .sdi_o(sdi),
                                        .sdo_i(sdo_bus));
    // Count a compare, report a mismatch at once
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // One full frame, response compared with the expected word
    task automatic fr(input logic [15:0] w, input logic [15:0] e);
        bdm_host_model_inst.xfer(16, w, r, g);
        chk(r, e);
    endtask
    task automatic close_out();
        if (miscompares == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wait_core(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Watchdog sized well beyond the whole sequence
    initial begin
        #500us;
        miscompares++;
        close_out();
    end
    // Main sequence: table rows, then latched and self-recovering faults
    initial begin
        wait_core(20);
        rst_b = 1'b1;
        wait_core(520);
        foreach (rows[i]) begin
            bdm_host_model_inst.xfer(rows[i].n, rows[i].w, r, g);
            chk(r & rows[i].m, rows[i].e & rows[i].m);
            chk({15'h0000, g}, {15'h0000, rows[i].g});
        end
        chk({7'h00, sdo_oe, drv}, 16'h000f);
        wait_core(1);
        ts = 1'b1;
        wait_core(6);
        chk({8'h00, drv}, 16'h0000);
        ts = 1'b0;
        wait_core(6);
        chk({8'h00, drv}, 16'h0000);
        bdm_host_model_inst.xfer(16, 16'h009b, r, g);
        chk(r, 16'h0c0c);
        wait_core(2);
        chk({8'h00, drv}, 16'h000f);
        ul = 1'b1;
        wait_core(6);
        chk({8'h00, drv}, 16'h0000);
        ul = 1'b0;
        wait_core(6);
        chk({8'h00, drv}, 16'h000f);
        fr(16'h009b, 16'h2828);
        // Warning latches with outputs on; it only clears once cool
        wait_core(1);
        tw = 1'b1;
        wait_core(6);
        chk({8'h00, drv}, 16'h000f);
        fr(16'h009b, 16'h0a0a);
        wait_core(1);
        tw = 1'b0;
        fr(16'h009b, 16'h0a0a);
        fr(16'h001b, 16'h0808);
        // Overvoltage switches off, recovers by itself, flag stays latched
        wait_core(1);
        ov = 1'b1;
        wait_core(6);
        chk({8'h00, drv}, 16'h0000);
        ov = 1'b0;
        wait_core(6);
        chk({8'h00, drv}, 16'h000f);
        fr(16'h009b, 16'h1818);
        // Open load on switch 0: latched, output kept, then masked from the fault bit
        wait_core(1);
        uc = 8'h01;
        wait_core(30);
        uc = 8'h00;
        chk({8'h00, drv}, 16'h000f);
        fr(16'h001b, 16'h4848);
        chk({15'h0000, g}, 16'h0001);
        fr(16'h01eb, 16'h0048);
        fr(16'h0007, 16'h0148);
        chk({15'h0000, g}, 16'h0000);
        // Overcurrent keeps its switch off until the host clears it
        wait_core(1);
        oc = 8'h02;
        wait_core(6);
        oc = 8'h00;
        wait_core(6);
        chk({8'h00, drv}, 16'h000d);
        fr(16'h00db, 16'h0248);
        wait_core(2);
        chk({8'h00, drv}, 16'h000f);
        // Sleep clears everything; an early frame must be dropped
        en = 1'b0;
        wait_core(6);
        chk({8'h00, drv}, 16'h0000);
        en = 1'b1;
        wait_core(6);
        bdm_host_model_inst.xfer(16, 16'h0f83, r, g);
        wait_core(520);
        bdm_host_model_inst.xfer(16, 16'h0003, r, g);
        chk(r, 16'h0000);
        chk({15'h0000, g}, 16'h0001);
        close_out();
    end
endmodule
